/* File: dv/gisp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gisp_host_model (
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   localparam int QTR = 100;

   // clock stands high between frames
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   // 400 ns per bit keeps the link inside the high speed rate
   task automatic put_bit(input logic b, output logic s);
      sda_low_o = ~b;
      #QTR scl_o = 1'b1;
      #QTR s = sda_i;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask : put_bit

   // only the host opens a frame
   task automatic start;
      sda_low_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR sda_low_o = 1'b1;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask : start

   task automatic stop;
      sda_low_o = 1'b1;
      #QTR scl_o = 1'b1;
      #QTR sda_low_o = 1'b0;
      #(2 * QTR);
   endtask : stop

   // n below 8 leaves a short word with no ack slot
   task automatic put_bits(input logic [7:0] d, input int n,
                           output logic ack);
      logic s;
      for (int i = 7; i > 7 - n; i--) put_bit(d[i], s);
      if (n == 8) put_bit(1'b1, s);
      ack = (n == 8) && (s === 1'b0);
   endtask : put_bits

   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(~ack, s);
   endtask : get_byte

   // msb first, no reflection, no final inversion
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++)
         r = {r[6:0], 1'b0} ^ (r[7] ? gisp_pkg::CRC_POLY[7:0] : 8'h00);
      return r;
   endfunction : crc8

   // mode 0 no check byte, 1 good, 2 corrupted; check byte last
   task automatic write_txn(input logic [6:0] a, input logic [7:0] r,
                            input logic [7:0] d, input int mode,
                            output logic ok);
      logic [7:0] c;
      logic [3:0] k;
      c = crc8(crc8(crc8(gisp_pkg::CRC_INIT, {a, 1'b0}), r), d);
      start();
      put_bits({a, 1'b0}, 8, k[0]);
      put_bits(r, 8, k[1]);
      put_bits(d, 8, k[2]);
      k[3] = 1'b1;
      if (mode != 0) put_bits(c ^ {7'h00, mode == 2}, 8, k[3]);
      stop();
      ok = &k;
   endtask : write_txn
endmodule : gisp_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
      end \
   end
module tb_top;
   localparam int TO = 2000;
   logic       core_clk_i  = 1'b0;
   logic       rst_i       = 1'b1;
   logic [2:0] addr_sel    = 3'h0;
   logic       crc_en      = 1'b0;
   logic       gw_en       = 1'b0;
   logic       tp_mode     = 1'b0;
   logic       pu_event    = 1'b0;
   logic [3:0] ov_ev       = 4'h0;
   logic [3:0] uv_ev       = 4'h0;
   logic [6:0] dev_addr    = gisp_pkg::ADDR_BASE;
   logic [7:0] start_cnt   = 8'h00;
   int         num_errors  = 0;
   int         comparisons = 0;
   wire logic       scl, host_low, sda_o, sda_oe, irq_n, pend, st_start;
   wire logic [6:0] c1;
   wire logic [3:0] vmon, ov_f, uv_f;
   // open drain with pull-up: low while either party pulls
   wire logic       sda_bus = ~(host_low | (sda_oe & ~sda_o));

   always #25 core_clk_i = ~core_clk_i;
   // start request is a one-cycle pulse, so count it
   always @(posedge core_clk_i) if (st_start) start_cnt <= start_cnt + 8'h01;

   gisp_host_model host (.sda_i(sda_bus), .scl_o(scl), .sda_low_o(host_low));

   gisp_slave #(.TIMEOUT_CYC(TO)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_sel_i(addr_sel), .crc_check_enable_i(crc_en),
      .guarded_write_enable_i(gw_en), .test_program_mode_in_i(tp_mode),
      .power_up_event_i(pu_event), .selftest_ov_event_i(ov_ev),
      .selftest_uv_event_i(uv_ev), .irq_out_n_o(irq_n),
      .thermal_monitor_enable_o(c1[0]),
      .input_overvolt_lockout_enable_o(c1[1]),
      .watchdog_input_reset_kind_o(c1[2]),
      .input_overvolt_shutdown_enable_o(c1[3]),
      .watchdog_counter_enable_o(c1[4]),
      .watchdog_standby_enable_o(c1[5]),
      .watchdog_input_standby_monitor_o(c1[6]),
      .regulator_voltage_monitor_enable_o(vmon),
      .selftest_overvolt_fault_flag_o(ov_f),
      .selftest_undervolt_fault_flag_o(uv_f),
      .selftest_start_o(st_start), .secure_write_pending_o(pend)
   );

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cycles

   task automatic cfg(input logic c, g, t, p, input logic [2:0] s);
      @(posedge core_clk_i);
      #1;
      {crc_en, gw_en, tp_mode, pu_event, addr_sel} = {c, g, t, p, s};
      cycles(4);
   endtask : cfg

   // commit lands a few core cycles after the stop
   task automatic wr(input logic [7:0] r, d, input int m);
      logic ok;
      host.write_txn(dev_addr, r, d, m, ok);
      cycles(4);
      `CHK(ok, 1'b1)
   endtask : wr

   task automatic rd(input logic [7:0] r, output logic [7:0] d);
      logic [2:0] a;
      host.start();
      host.put_bits({dev_addr, 1'b0}, 8, a[0]);
      host.put_bits(r, 8, a[1]);
      host.start();
      host.put_bits({dev_addr, 1'b1}, 8, a[2]);
      host.get_byte(1'b0, d);
      host.stop();
      cycles(4);
      `CHK(a, 3'b111)
   endtask : rd

   task automatic echo;
      logic [7:0] code;
      rd(gisp_pkg::REG_CODE, code);
      wr(gisp_pkg::REG_ECHO, code, 0);
   endtask : echo

   task automatic t_reset;
      `CHK(c1, gisp_pkg::CTRL1_RST[6:0])
      `CHK(vmon, gisp_pkg::VMON_RST)
      `CHK({ov_f, uv_f, pend, irq_n}, 10'h001)
   endtask : t_reset

   task automatic t_addr;
      logic a, b;
      for (int s = 0; s < 8; s++) begin
         cfg(0, 0, 0, 0, s[2:0]);
         host.start();
         host.put_bits({dev_addr + 7'(s), 1'b0}, 8, a);
         host.stop();
         host.start();
         host.put_bits({dev_addr + 7'((s + 1) % 8), 1'b0}, 8, b);
         host.stop();
         `CHK({a, b}, 2'b10)
      end
      cfg(0, 0, 0, 0, 3'h0);
   endtask : t_addr

   task automatic t_partial;
      logic a;
      wr(gisp_pkg::REG_VMON, 8'h06, 0);
      host.start();
      host.put_bits({dev_addr, 1'b0}, 8, a);
      host.put_bits(gisp_pkg::REG_VMON, 8, a);
      host.put_bits(8'h09, 7, a);
      host.stop();
      cycles(4);
      `CHK(vmon, 4'h6)
   endtask : t_partial

   task automatic t_crc;
      logic [7:0] d;
      cfg(1, 0, 0, 0, 3'h0);
      wr(gisp_pkg::REG_VMON, 8'h05, 1);
      `CHK(vmon, 4'h5)
      wr(gisp_pkg::REG_VMON, 8'h0A, 2);
      `CHK({vmon, irq_n}, 5'h0A)
      rd(gisp_pkg::REG_STATUS, d);
      `CHK(d[0], 1'b1)
      wr(gisp_pkg::REG_MASK, 8'h01, 1);
      `CHK(irq_n, 1'b1)
      wr(gisp_pkg::REG_MASK, 8'h00, 1);
      `CHK(irq_n, 1'b0)
      wr(gisp_pkg::REG_STATUS, 8'h01, 1);
      `CHK(irq_n, 1'b1)
      cfg(0, 0, 0, 0, 3'h0);
      wr(gisp_pkg::REG_VMON, 8'h0C, 0);
      `CHK(vmon, 4'hC)
   endtask : t_crc

   task automatic t_secure;
      logic [7:0] d;
      cfg(0, 1, 0, 0, 3'h0);
      wr(gisp_pkg::REG_VMON, 8'h03, 0);
      `CHK({vmon, pend}, 5'b11001)
      rd(gisp_pkg::REG_CODE, d);
      `CHK(d !== 8'h00, 1'b1)
      wr(gisp_pkg::REG_ECHO, d, 0);
      `CHK({vmon, pend}, 5'b00110)
      rd(gisp_pkg::REG_CODE, d);
      `CHK(d, 8'h00)
      wr(gisp_pkg::REG_VMON, 8'h01, 0);
      rd(gisp_pkg::REG_CODE, d);
      wr(gisp_pkg::REG_ECHO, d ^ 8'h01, 0);
      `CHK({vmon, pend}, 5'b00110)
      rd(gisp_pkg::REG_ECHO, d);
      `CHK(d, 8'h00)
      wr(gisp_pkg::REG_CTRL1, 8'hEB, 0);
      `CHK(pend, 1'b1)
      wr(gisp_pkg::REG_MASK, 8'h01, 0);
      `CHK({c1, pend}, {gisp_pkg::CTRL1_RST[6:0], 1'b0})
      rd(gisp_pkg::REG_MASK, d);
      `CHK(d[0], 1'b1)
      wr(gisp_pkg::REG_MASK, 8'h00, 0);
   endtask : t_secure

   task automatic t_flags;
      @(posedge core_clk_i);
      #1;
      {ov_ev, uv_ev} = 8'h28;
      @(posedge core_clk_i);
      #1;
      {ov_ev, uv_ev} = 8'h00;
      cycles(2);
      `CHK({ov_f, uv_f}, 8'h28)
      wr(gisp_pkg::REG_ST_OV, 8'h02, 0);
      `CHK({ov_f, pend}, 5'b00101)
      echo();
      `CHK(ov_f, 4'h0)
      wr(gisp_pkg::REG_ST_UV, 8'h08, 0);
      echo();
      `CHK(uv_f, 4'h0)
      wr(gisp_pkg::REG_ST_RUN, 8'h01, 0);
      `CHK(start_cnt, 8'h00)
      echo();
      `CHK(start_cnt, 8'h01)
   endtask : t_flags

   // the wait window brackets the timeout from both sides
   task automatic t_timeout;
      wr(gisp_pkg::REG_CTRL1, 8'hFF, 0);
      cycles(TO - 100);
      `CHK({c1[2], pend}, 2'b01)
      cycles(200);
      `CHK({c1[2], pend}, 2'b00)
      wr(gisp_pkg::REG_CTRL1, 8'hFF, 0);
      echo();
      `CHK({c1[2], pend}, 2'b10)
   endtask : t_timeout

   task automatic t_test;
      logic a;
      cfg(1, 1, 1, 0, 3'h5);
      wr(gisp_pkg::REG_VMON, 8'h00, 0);
      `CHK({vmon, pend}, 5'b00000)
      host.start();
      host.put_bits({dev_addr + 7'h05, 1'b0}, 8, a);
      host.stop();
      `CHK(a, 1'b0)
      cfg(1, 1, 1, 1, 3'h5);
      wr(gisp_pkg::REG_VMON, 8'h0F, 0);
      `CHK(vmon, 4'h0)
   endtask : t_test

   task automatic end_of_test;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   initial begin
      cycles(3);
      #1;
      rst_i = 1'b0;
      cycles(4);
      t_reset();
      t_addr();
      t_partial();
      t_crc();
      t_secure();
      t_flags();
      t_timeout();
      t_test();
      end_of_test();
   end

   // whole run needs roughly 0.7 ms of link traffic
   initial begin
      #3ms;
      num_errors++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire

/* File: logic/gisp_crc8.sv */
`timescale 1ns/1ps
`default_nettype none
module gisp_crc8 (
   input  wire logic [7:0] crc_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] crc_o
);
   always_comb begin
      logic [7:0] c;
      c = crc_i ^ data_i;
      for (int i = 0; i < 8; i++) begin
         if (c[7]) begin
            c = {c[6:0], 1'b0} ^ gisp_pkg::CRC_POLY[7:0];
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc_o = c;
   end
endmodule : gisp_crc8
`default_nettype wire

/* File: logic/gisp_pkg.sv */
`default_nettype none
package gisp_pkg;
   localparam int CLK_HZ         = 20_000_000;
   localparam int SW_TIMEOUT_MS  = 10;
   localparam int SW_TIMEOUT_CYC = (CLK_HZ / 1000) * SW_TIMEOUT_MS;

   localparam logic [6:0] ADDR_BASE = 7'h08;
   localparam logic [8:0] CRC_POLY  = 9'h11D;
   localparam logic [7:0] CRC_INIT  = 8'hFF;
   localparam logic [7:0] LFSR_SEED = 8'h01;

   // register offsets inside the port's own map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK   = 8'h01;
   localparam logic [7:0] REG_CTRL1  = 8'h02;
   localparam logic [7:0] REG_VMON   = 8'h03;
   localparam logic [7:0] REG_ST_OV  = 8'h04;
   localparam logic [7:0] REG_ST_UV  = 8'h05;
   localparam logic [7:0] REG_ST_RUN = 8'h06;
   localparam logic [7:0] REG_CODE   = 8'h07;
   localparam logic [7:0] REG_ECHO   = 8'h08;

   // control, status and run register bit positions
   localparam int C1_THERM  = 0;
   localparam int C1_OVLO   = 1;
   localparam int C1_WDMODE = 2;
   localparam int C1_SDWN   = 3;
   localparam int C1_WD     = 4;
   localparam int C1_WDSTBY = 5;
   localparam int C1_WDIMON = 6;
   localparam int C1_SECURE = 7;
   localparam int ST_CRC    = 0;
   localparam int RUN_START = 0;

   localparam logic [7:0] CTRL1_RST       = 8'hFB;
   localparam logic [7:0] CTRL1_CLR_GUARD = 8'hFB;
   localparam logic [3:0] VMON_RST        = 4'hF;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK
   } gisp_state_e;
endpackage : gisp_pkg
`default_nettype wire

/* File: logic/gisp_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - I2C control port, high speed to 3.4 MHz
// - device is slave only, host masters
// - address 0x08 plus three-bit select code
// - data latched only after eighth bit
// - seven-bit word: no write, no ack
// - check-enable bit turns CRC check on
// - CRC computed over every write transaction
// - CRC mismatch drops write, flags, interrupts
// - CRC-8 polynomial 0x11D, initial 0xFF
// - guarded-write enable bit turns handshake on
// - guarded write held, random challenge generated
// - matching echo applies write, clears both
// - mismatching echo drops write, clears both
// - other unguarded write aborts, executes normally
// - no echo within 10 ms abandons write
// - self-test flags and start are guarded
// - clearing monitor and watchdog enables guarded
// - mode bit picks soft or hard reset
// - test mode: fixed address, checks bypassed unless power-up event
module gisp_slave #(
   parameter int TIMEOUT_CYC = gisp_pkg::SW_TIMEOUT_CYC
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [2:0] addr_sel_i,
   input  wire logic       crc_check_enable_i,
   input  wire logic       guarded_write_enable_i,
   input  wire logic       test_program_mode_in_i,
   input  wire logic       power_up_event_i,
   input  wire logic [3:0] selftest_ov_event_i,
   input  wire logic [3:0] selftest_uv_event_i,
   output logic            irq_out_n_o,
   output logic            thermal_monitor_enable_o,
   output logic            input_overvolt_lockout_enable_o,
   output logic            watchdog_input_reset_kind_o,
   output logic            input_overvolt_shutdown_enable_o,
   output logic            watchdog_counter_enable_o,
   output logic            watchdog_standby_enable_o,
   output logic            watchdog_input_standby_monitor_o,
   output logic [3:0]      regulator_voltage_monitor_enable_o,
   output logic [3:0]      selftest_overvolt_fault_flag_o,
   output logic [3:0]      selftest_undervolt_fault_flag_o,
   output logic            selftest_start_o,
   output logic            secure_write_pending_o
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [TW-1:0] TMAX = TW'(TIMEOUT_CYC - 1);

   // pins are synchronised as one vector; static straps ride along
   logic [8:0] sync1, sync2;
   logic       scl_d, sda_d;
   wire  [8:0] pins = {power_up_event_i, test_program_mode_in_i,
                       guarded_write_enable_i, crc_check_enable_i,
                       addr_sel_i, sda_i, scl_i};
   wire        scl_q  = sync2[0];
   wire        sda_q  = sync2[1];
   wire  [2:0] sel_q  = sync2[4:2];
   wire        bypass = sync2[7] & ~sync2[8];

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync1 <= 9'h003;
         sync2 <= 9'h003;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (ce_i) begin
         sync1 <= pins;
         sync2 <= sync1;
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end

   wire scl_rise = ce_i & scl_q & ~scl_d;
   wire scl_fall = ce_i & ~scl_q & scl_d;
   wire start_c  = ce_i & scl_q & scl_d & sda_d & ~sda_q;
   wire stop_c   = ce_i & scl_q & scl_d & ~sda_d & sda_q;

   wire       crc_on = sync2[5] & ~bypass;
   logic [7:0] ctrl1;
   wire       sec_on = sync2[6] & ctrl1[gisp_pkg::C1_SECURE]
                       & ~bypass;
   wire [6:0] dev_addr = sync2[7] ? gisp_pkg::ADDR_BASE
                         : gisp_pkg::ADDR_BASE + {4'h0, sel_q};

   gisp_pkg::gisp_state_e state;
   logic [3:0] bitcnt;
   logic [7:0] shift, tx, ptr, data_b, crc_b, crc_c, crc_nx, rd_data;
   logic       ack_drv, wr_txn, mack;
   logic [1:0] nbyte;
   wire  [7:0] next_shift = {shift[6:0], sda_q};
   wire        addr_hit   = shift[7:1] == dev_addr;
   wire        in_tx      = state == gisp_pkg::S_TX;

   gisp_crc8 u_crc (
      .crc_i  (crc_c),
      .data_i (shift),
      .crc_o  (crc_nx)
   );

   assign sda_o    = 1'b0;
   assign sda_oe_o = ack_drv | (in_tx & ~tx[7]);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state   <= gisp_pkg::S_IDLE;
         bitcnt  <= 4'h0;
         shift   <= 8'h00;
         tx      <= 8'h00;
         ack_drv <= 1'b0;
         wr_txn  <= 1'b0;
         mack    <= 1'b0;
         nbyte   <= 2'h0;
         ptr     <= 8'h00;
         data_b  <= 8'h00;
         crc_b   <= 8'h00;
         crc_c   <= gisp_pkg::CRC_INIT;
      end else if (start_c) begin
         state   <= gisp_pkg::S_ADDR;
         bitcnt  <= 4'h0;
         ack_drv <= 1'b0;
         wr_txn  <= 1'b0;
         nbyte   <= 2'h0;
         crc_c   <= gisp_pkg::CRC_INIT;
      end else if (stop_c) begin
         state   <= gisp_pkg::S_IDLE;
         ack_drv <= 1'b0;
         wr_txn  <= 1'b0;
      end else if (scl_rise) begin
         if (state == gisp_pkg::S_ADDR || state == gisp_pkg::S_RX) begin
            shift  <= next_shift;
            bitcnt <= bitcnt + 4'h1;
         end
         if (state == gisp_pkg::S_TX_ACK) begin
            mack <= ~sda_q;
            if (!sda_q) begin
               ptr <= ptr + 8'h01;
            end
         end
      end else if (scl_fall) begin
         unique case (state)
            gisp_pkg::S_IDLE: ;
            gisp_pkg::S_ADDR: if (bitcnt == 4'h8) begin
               // only answers its own address, never masters
               if (addr_hit) begin
                  ack_drv <= 1'b1;
                  wr_txn  <= ~shift[0];
                  crc_c   <= crc_nx;
                  state   <= gisp_pkg::S_ADDR_ACK;
               end else begin
                  state   <= gisp_pkg::S_IDLE;
               end
            end
            gisp_pkg::S_ADDR_ACK: begin
               ack_drv <= 1'b0;
               bitcnt  <= 4'h0;
               if (shift[0]) begin
                  tx    <= rd_data;
                  state <= gisp_pkg::S_TX;
               end else begin
                  state <= gisp_pkg::S_RX;
               end
            end
            gisp_pkg::S_RX: if (bitcnt == 4'h8) begin
               // a word is taken and acked only once full
               ack_drv <= 1'b1;
               state   <= gisp_pkg::S_RX_ACK;
               if (nbyte == 2'h0) begin
                  ptr   <= shift;
                  crc_c <= crc_nx;
               end
               if (nbyte == 2'h1) begin
                  data_b <= shift;
                  crc_c  <= crc_nx;
               end
               if (nbyte == 2'h2) begin
                  crc_b <= shift;
               end
               if (nbyte != 2'h3) begin
                  nbyte <= nbyte + 2'h1;
               end
            end
            gisp_pkg::S_RX_ACK: begin
               ack_drv <= 1'b0;
               bitcnt  <= 4'h0;
               state   <= gisp_pkg::S_RX;
            end
            gisp_pkg::S_TX: if (bitcnt == 4'h7) begin
               state <= gisp_pkg::S_TX_ACK;
            end else begin
               tx     <= {tx[6:0], 1'b0};
               bitcnt <= bitcnt + 4'h1;
            end
            gisp_pkg::S_TX_ACK: if (mack) begin
               tx     <= rd_data;
               bitcnt <= 4'h0;
               state  <= gisp_pkg::S_TX;
            end else begin
               state  <= gisp_pkg::S_IDLE;
            end
            default: state <= gisp_pkg::S_IDLE;
         endcase
      end
   end

   // register file and guarded-write handshake
   logic [3:0]    vmon, st_ov, st_uv;
   logic [7:0]    code, echo, pend_ptr, pend_data, lfsr;
   logic          st_run, crc_flag, irq_mask, pending;
   logic [TW-1:0] pend_cnt;

   // a write only commits at the stop or restart that ends it
   wire commit   = (start_c | stop_c) & wr_txn & nbyte[1];
   wire crc_ok   = ~crc_on
                   | (nbyte == 2'h3 && crc_b == crc_c);
   wire do_write = commit & crc_ok;
   wire crc_fail = commit & ~crc_ok;
   wire to_echo  = ptr == gisp_pkg::REG_ECHO;

   wire [7:0] c1_clr = ctrl1 & ~data_b & gisp_pkg::CTRL1_CLR_GUARD;
   wire g_ctrl = (ptr == gisp_pkg::REG_CTRL1)
                 & ((|c1_clr) | (ctrl1[gisp_pkg::C1_WDMODE]
                    ^ data_b[gisp_pkg::C1_WDMODE]));
   wire g_vmon = (ptr == gisp_pkg::REG_VMON)
                 & (|(vmon & ~data_b[3:0]));
   wire g_st   = (ptr == gisp_pkg::REG_ST_OV | ptr == gisp_pkg::REG_ST_UV)
                 & (|data_b[3:0]);
   wire g_run  = (ptr == gisp_pkg::REG_ST_RUN)
                 & data_b[gisp_pkg::RUN_START];
   wire guard_hit = sec_on & (g_ctrl | g_vmon | g_st | g_run);

   wire hold_now   = do_write & guard_hit;
   wire echo_done  = do_write & pending & to_echo;
   wire abort      = do_write & pending & ~to_echo & ~guard_hit;
   wire tmo        = pending & (pend_cnt == TMAX);
   wire apply_now  = do_write & ~guard_hit & ~to_echo;
   wire apply_pend = echo_done & (data_b == code);
   wire       wr_en   = apply_now | apply_pend;
   wire [7:0] wr_ptr  = apply_pend ? pend_ptr : ptr;
   wire [7:0] wr_data = apply_pend ? pend_data : data_b;
   wire [3:0] ov_clr  = (wr_en && wr_ptr == gisp_pkg::REG_ST_OV)
                        ? wr_data[3:0] : 4'h0;
   wire [3:0] uv_clr  = (wr_en && wr_ptr == gisp_pkg::REG_ST_UV)
                        ? wr_data[3:0] : 4'h0;
   wire       crc_clr = wr_en && wr_ptr == gisp_pkg::REG_STATUS
                        && wr_data[gisp_pkg::ST_CRC];
   wire [7:0] next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl1     <= gisp_pkg::CTRL1_RST;
         vmon      <= gisp_pkg::VMON_RST;
         st_ov     <= 4'h0;
         st_uv     <= 4'h0;
         st_run    <= 1'b0;
         crc_flag  <= 1'b0;
         irq_mask  <= 1'b0;
         code      <= 8'h00;
         echo      <= 8'h00;
         pending   <= 1'b0;
         pend_ptr  <= 8'h00;
         pend_data <= 8'h00;
         pend_cnt  <= '0;
         lfsr      <= gisp_pkg::LFSR_SEED;
      end else if (ce_i) begin
         // free-running so the code depends on host timing
         lfsr     <= next_lfsr;
         st_ov    <= (st_ov & ~ov_clr) | selftest_ov_event_i;
         st_uv    <= (st_uv & ~uv_clr) | selftest_uv_event_i;
         st_run   <= wr_en && wr_ptr == gisp_pkg::REG_ST_RUN
                     && wr_data[gisp_pkg::RUN_START];
         crc_flag <= crc_fail | (crc_flag & ~crc_clr);
         if (wr_en && wr_ptr == gisp_pkg::REG_CTRL1) begin
            ctrl1 <= wr_data;
         end
         if (wr_en && wr_ptr == gisp_pkg::REG_VMON) begin
            vmon <= wr_data[3:0];
         end
         if (wr_en && wr_ptr == gisp_pkg::REG_MASK) begin
            irq_mask <= wr_data[0];
         end
         pend_cnt <= pending ? pend_cnt + 1'b1 : '0;
         if (hold_now) begin
            pending   <= 1'b1;
            pend_ptr  <= ptr;
            pend_data <= data_b;
            code      <= lfsr;
            echo      <= 8'h00;
            pend_cnt  <= '0;
         end else if (echo_done | abort | tmo) begin
            pending <= 1'b0;
            code    <= 8'h00;
            echo    <= 8'h00;
         end else if (do_write && to_echo) begin
            echo <= data_b;
         end
      end
   end

   always_comb begin
      unique case (ptr)
         gisp_pkg::REG_STATUS: rd_data = {7'h00, crc_flag};
         gisp_pkg::REG_MASK:   rd_data = {7'h00, irq_mask};
         gisp_pkg::REG_CTRL1:  rd_data = ctrl1;
         gisp_pkg::REG_VMON:   rd_data = {4'h0, vmon};
         gisp_pkg::REG_ST_OV:  rd_data = {4'h0, st_ov};
         gisp_pkg::REG_ST_UV:  rd_data = {4'h0, st_uv};
         gisp_pkg::REG_CODE:   rd_data = code;
         gisp_pkg::REG_ECHO:   rd_data = echo;
         default:              rd_data = 8'h00;
      endcase
   end

   assign irq_out_n_o = ~(crc_flag & ~irq_mask);
   assign thermal_monitor_enable_o = ctrl1[gisp_pkg::C1_THERM];
   assign input_overvolt_lockout_enable_o = ctrl1[gisp_pkg::C1_OVLO];
   assign watchdog_input_reset_kind_o = ctrl1[gisp_pkg::C1_WDMODE];
   assign input_overvolt_shutdown_enable_o = ctrl1[gisp_pkg::C1_SDWN];
   assign watchdog_counter_enable_o = ctrl1[gisp_pkg::C1_WD];
   assign watchdog_standby_enable_o = ctrl1[gisp_pkg::C1_WDSTBY];
   assign watchdog_input_standby_monitor_o = ctrl1[gisp_pkg::C1_WDIMON];
   assign regulator_voltage_monitor_enable_o = vmon;
   assign selftest_overvolt_fault_flag_o  = st_ov;
   assign selftest_undervolt_fault_flag_o = st_uv;
   assign selftest_start_o       = st_run;
   assign secure_write_pending_o = pending;

   chk_foreign_addr: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (scl_fall && state == gisp_pkg::S_ADDR
      && bitcnt == 4'h8 && !addr_hit) |=> !ack_drv && !sda_oe_o)
      else $error("acked a foreign address");
   chk_partial_nack: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (state == gisp_pkg::S_RX && bitcnt < 4'h8)
      |-> !sda_oe_o) else $error("ack driven before eighth bit");
   chk_crc_drop: assert property (@(posedge core_clk_i)
      disable iff (rst_i) crc_fail |-> !wr_en ##1 crc_flag)
      else $error("crc failure not dropped or flagged");
   chk_irq_level: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (crc_fail && !irq_mask && ce_i)
      |=> !irq_out_n_o) else $error("interrupt not raised");
   chk_guard_hold: assert property (@(posedge core_clk_i)
      disable iff (rst_i) hold_now |=> pending && code != 8'h00
      && ctrl1 == $past(ctrl1) && vmon == $past(vmon))
      else $error("guarded write took effect at once");
   chk_echo_clear: assert property (@(posedge core_clk_i)
      disable iff (rst_i) echo_done |=> !pending && code == 8'h00
      && echo == 8'h00) else $error("handshake not cleared");
   chk_echo_bad: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (echo_done && data_b != code) |-> !wr_en)
      else $error("mismatched echo applied");
   chk_timeout: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (ce_i && tmo && !do_write) |=> !pending)
      else $error("pending write not abandoned");
   chk_test_bypass: assert property (@(posedge core_clk_i)
      disable iff (rst_i) bypass |-> !crc_on && !sec_on
      && dev_addr == gisp_pkg::ADDR_BASE)
      else $error("test mode bypass not applied");
   cov_guard_ok: cover property (@(posedge core_clk_i) apply_pend);
   cov_crc_fail: cover property (@(posedge core_clk_i) crc_fail);
   cov_read: cover property (@(posedge core_clk_i)
      state == gisp_pkg::S_TX_ACK && scl_fall && mack);
endmodule : gisp_slave
`default_nettype wire
